// File: core/ea_disp_scaler.sv
`default_nettype none
module ea_disp_scaler #(
  parameter int unsigned DISP_W = 8
) (
  input  wire logic [DISP_W-1:0]          disp_in,
  input  wire ea_gen_pkg::op_size_e       size_in,
  output logic [ea_gen_pkg::DATA_W-1:0]   scaled_out
);
  import ea_gen_pkg::*;

  // Refuse widths outside 1 to 24 bits
  generate
    if (DISP_W < 1 || DISP_W > 24) begin : g_bad_width
      $error("ea_disp_scaler: DISP_W out of range");
    end
  endgenerate

  logic [DATA_W-1:0] ext;

  // Zero-extend, then scale by 1, 2 or 4
  always_comb begin
    ext = {{(DATA_W-DISP_W){1'b0}}, disp_in};
    unique case (size_in)
      SIZE_BYTE: scaled_out = ext;
      SIZE_WORD: scaled_out = {ext[DATA_W-2:0], 1'b0};
      SIZE_LONG: scaled_out = {ext[DATA_W-3:0], 2'b00};
      default:   scaled_out = ext;
    endcase
  end

endmodule
`default_nettype wire

// File: core/effective_address_generator.sv
`default_nettype none
module effective_address_generator (
  input  wire logic                      ref_clk_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      req_valid_in,
  input  wire ea_gen_pkg::ea_mode_e      mode_in,
  input  wire ea_gen_pkg::op_size_e      size_in,
  input  wire ea_gen_pkg::imm_kind_e     imm_kind_in,
  input  wire logic [31:0]               selected_general_reg_in,
  input  wire logic [31:0]               index_reg_zero_in,
  input  wire logic [31:0]               global_base_reg_in,
  input  wire logic [31:0]               pc_in,
  input  wire logic [11:0]               disp_in,
  input  wire logic [7:0]                imm_in,
  output logic                           valid_out,
  output logic [31:0]                    ea_out,
  output logic [31:0]                    operand_out,
  output logic                           mem_access_out,
  output logic                           branch_out,
  output logic                           wb_valid_out,
  output logic [31:0]                    wb_value_out,
  output logic                           addr_error_out
);
  import ea_gen_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Step for the operand size
  function automatic logic [DATA_W-1:0] size_step(input op_size_e s);
    unique case (s)
      SIZE_BYTE: size_step = STEP_BYTE;
      SIZE_WORD: size_step = STEP_WORD;
      SIZE_LONG: size_step = STEP_LONG;
      default:   size_step = STEP_BYTE;
    endcase
  endfunction

  // Alignment check; bytes may sit anywhere
  function automatic logic misaligned(input logic [DATA_W-1:0] a, input op_size_e s);
    unique case (s)
      SIZE_WORD: misaligned = a[0];
      SIZE_LONG: misaligned = |a[1:0];
      default:   misaligned = 1'b0;
    endcase
  endfunction

  // Sum helper keeps 32-bit wrap explicit
  function automatic logic [DATA_W-1:0] sel_plus(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    sel_plus = a + b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand preparation

  logic [DATA_W-1:0] step;
  logic [DATA_W-1:0] post_value;
  logic [DATA_W-1:0] pre_value;
  logic [DATA_W-1:0] disp4_scaled;
  logic [DATA_W-1:0] disp8_scaled;
  logic [DATA_W-1:0] pc_disp_scaled;
  logic [DATA_W-1:0] pc_base;
  logic [DATA_W-1:0] branch8_off;
  logic [DATA_W-1:0] branch12_off;
  logic [DATA_W-1:0] imm_value;
  op_size_e          pc_size;

  // Register update values, carries dropped
  assign step       = size_step(size_in);
  assign post_value = sel_plus(selected_general_reg_in, step);
  assign pre_value  = selected_general_reg_in - step;

  // PC literal scale is four for longwords, two for bytes and words
  assign pc_size = (size_in == SIZE_LONG) ? SIZE_LONG : SIZE_WORD;
  assign pc_base = (size_in == SIZE_LONG) ? (pc_in & PC_LONG_MASK) : pc_in;

  // Scaled zero-extended displacements
  ea_disp_scaler #(.DISP_W(DISP4_W)) u_scale_d4 (
    .disp_in    (disp_in[DISP4_W-1:0]),
    .size_in    (size_in),
    .scaled_out (disp4_scaled)
  );

  ea_disp_scaler #(.DISP_W(DISP8_W)) u_scale_d8 (
    .disp_in    (disp_in[DISP8_W-1:0]),
    .size_in    (size_in),
    .scaled_out (disp8_scaled)
  );

  ea_disp_scaler #(.DISP_W(DISP8_W)) u_scale_pc (
    .disp_in    (disp_in[DISP8_W-1:0]),
    .size_in    (pc_size),
    .scaled_out (pc_disp_scaled)
  );

  // Sign-extended, doubled branch offsets
  assign branch8_off  = {{(DATA_W-DISP8_W-1){disp_in[DISP8_W-1]}}, disp_in[DISP8_W-1:0], 1'b0};
  assign branch12_off = {{(DATA_W-DISP12_W-1){disp_in[DISP12_W-1]}}, disp_in[DISP12_W-1:0], 1'b0};

  // Immediate extension by instruction class
  always_comb begin
    unique case (imm_kind_in)
      IMM_ZERO_EXT: imm_value = {{(DATA_W-IMM_W){1'b0}}, imm_in};
      IMM_SIGN_EXT: imm_value = {{(DATA_W-IMM_W){imm_in[IMM_W-1]}}, imm_in};
      IMM_TRAP:     imm_value = {{(DATA_W-IMM_W-2){1'b0}}, imm_in, 2'b00};
      default:      imm_value = {{(DATA_W-IMM_W){1'b0}}, imm_in};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection

  logic [DATA_W-1:0] ea_d;
  logic [DATA_W-1:0] operand_d;
  logic [DATA_W-1:0] wb_value_d;
  logic              mem_d;
  logic              branch_d;
  logic              wb_d;
  logic              err_d;

  // Address, operand and write-back per mode
  always_comb begin
    ea_d       = RESET_WORD;
    operand_d  = RESET_WORD;
    wb_value_d = RESET_WORD;
    mem_d      = mode_in inside {MODE_REG_INDIRECT, MODE_POST_INC, MODE_PRE_DEC, MODE_REG_DISP4,
                                 MODE_INDEXED_REG, MODE_GLOBAL_DISP8, MODE_INDEXED_GLOBAL, MODE_PC_DISP8};
    branch_d   = mode_in inside {MODE_BRANCH8, MODE_BRANCH12, MODE_PC_PLUS_REG};
    wb_d       = 1'b0;
    unique case (mode_in)
      MODE_REG_DIRECT:     operand_d = selected_general_reg_in;
      MODE_REG_INDIRECT:   ea_d = selected_general_reg_in;
      MODE_POST_INC: begin
        ea_d       = selected_general_reg_in;
        wb_d       = 1'b1;
        wb_value_d = post_value;
      end
      MODE_PRE_DEC: begin
        ea_d       = pre_value;
        wb_d       = 1'b1;
        wb_value_d = pre_value;
      end
      MODE_REG_DISP4:      ea_d = selected_general_reg_in + disp4_scaled;
      MODE_INDEXED_REG:    ea_d = selected_general_reg_in + index_reg_zero_in;
      MODE_GLOBAL_DISP8:   ea_d = global_base_reg_in + disp8_scaled;
      MODE_INDEXED_GLOBAL: ea_d = global_base_reg_in + index_reg_zero_in;
      MODE_PC_DISP8:       ea_d = pc_base + pc_disp_scaled;
      MODE_BRANCH8:        ea_d = pc_in + branch8_off;
      MODE_BRANCH12:       ea_d = pc_in + branch12_off;
      MODE_PC_PLUS_REG:    ea_d = pc_in + selected_general_reg_in;
      MODE_IMMEDIATE:      operand_d = imm_value;
      default:             operand_d = RESET_WORD;
    endcase
  end

  // Alignment fault only on data accesses
  assign err_d = mem_d & misaligned(ea_d, (mode_in == MODE_PC_DISP8) ? pc_size : size_in);

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  logic              valid_q;
  logic [DATA_W-1:0] ea_q;
  logic [DATA_W-1:0] operand_q;
  logic              mem_q;
  logic              branch_q;
  logic              wb_q;
  logic [DATA_W-1:0] wb_value_q;
  logic              err_q;

  // Result valid one cycle after request
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= req_valid_in;
    end
  end

  // Address and operand result
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ea_q      <= RESET_WORD;
      operand_q <= RESET_WORD;
      mem_q     <= 1'b0;
      branch_q  <= 1'b0;
    end else if (req_valid_in) begin
      ea_q      <= ea_d;
      operand_q <= operand_d;
      mem_q     <= mem_d;
      branch_q  <= branch_d;
    end else begin
      mem_q     <= 1'b0;
      branch_q  <= 1'b0;
    end
  end

  // Register write-back for increment and decrement
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wb_q       <= 1'b0;
      wb_value_q <= RESET_WORD;
    end else begin
      wb_q <= req_valid_in & wb_d;
      if (req_valid_in & wb_d) begin
        wb_value_q <= wb_value_d;
      end
    end
  end

  // Address error flag
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_q <= 1'b0;
    end else begin
      err_q <= req_valid_in & err_d;
    end
  end

  assign valid_out      = valid_q;
  assign ea_out         = ea_q;
  assign operand_out    = operand_q;
  assign mem_access_out = mem_q;
  assign branch_out     = branch_q;
  assign wb_valid_out   = wb_q;
  assign wb_value_out   = wb_value_q;
  assign addr_error_out = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_direct;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_REG_DIRECT) |=>
        (operand_out == $past(selected_general_reg_in)) && !mem_access_out && !wb_valid_out;
  endproperty
  a_direct: assert property (p_direct) else $error("register direct result wrong");

  property p_indirect;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_REG_INDIRECT) |=> mem_access_out && (ea_out == $past(selected_general_reg_in));
  endproperty
  a_indirect: assert property (p_indirect) else $error("register indirect address wrong");

  property p_post_inc;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_POST_INC && size_in == SIZE_LONG) |=>
        wb_valid_out && (ea_out == $past(selected_general_reg_in))
        && (wb_value_out == $past(selected_general_reg_in) + 32'h0000_0004);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post-increment wrong");

  property p_pre_dec;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_PRE_DEC && size_in == SIZE_WORD) |=>
        wb_valid_out && (ea_out == wb_value_out) && (ea_out == $past(selected_general_reg_in) - 32'h0000_0002);
  endproperty
  a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement wrong");

  property p_disp4;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_REG_DISP4 && size_in == SIZE_LONG) |=>
        ea_out == $past(selected_general_reg_in) + {26'h0, $past(disp_in[3:0]), 2'b00};
  endproperty
  a_disp4: assert property (p_disp4) else $error("4-bit displacement address wrong");

  property p_indexed;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_INDEXED_REG) |=>
        ea_out == $past(selected_general_reg_in) + $past(index_reg_zero_in);
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_global_disp;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_GLOBAL_DISP8 && size_in == SIZE_WORD) |=>
        ea_out == $past(global_base_reg_in) + {23'h0, $past(disp_in[7:0]), 1'b0};
  endproperty
  a_global_disp: assert property (p_global_disp) else $error("global base displacement wrong");

  property p_pc_long;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_PC_DISP8 && size_in == SIZE_LONG) |=>
        ea_out == {$past(pc_in[31:2]), 2'b00} + {22'h0, $past(disp_in[7:0]), 2'b00};
  endproperty
  a_pc_long: assert property (p_pc_long) else $error("longword PC literal address wrong");

  property p_branch12;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_BRANCH12) |=>
        branch_out && (ea_out == $past(pc_in) + {{19{$past(disp_in[11])}}, $past(disp_in[11:0]), 1'b0});
  endproperty
  a_branch12: assert property (p_branch12) else $error("12-bit branch target wrong");

  property p_trap;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_IMMEDIATE && imm_kind_in == IMM_TRAP) |=>
        operand_out == {22'h0, $past(imm_in), 2'b00};
  endproperty
  a_trap: assert property (p_trap) else $error("trap immediate wrong");

  property p_align;
    @(posedge ref_clk_in) disable iff (!arst_n_in)
      (req_valid_in && mode_in == MODE_REG_INDIRECT && size_in == SIZE_LONG) |=>
        addr_error_out == ($past(selected_general_reg_in[1:0]) != 2'b00);
  endproperty
  a_align: assert property (p_align) else $error("address error flag wrong");

endmodule
`default_nettype wire

// File: dv/effective_address_generator_tb_top.sv
`default_nettype none
module effective_address_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ea_gen_pkg::*;

  logic        ref_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic        req_valid = 1'b0;
  ea_mode_e    mode      = MODE_REG_DIRECT;
  op_size_e    size      = SIZE_BYTE;
  imm_kind_e   kind      = IMM_ZERO_EXT;
  logic [31:0] gen_reg   = 32'h0;
  logic [31:0] idx_reg   = 32'h0;
  logic [31:0] gbase     = 32'h0;
  logic [31:0] pc        = 32'h0;
  logic [11:0] disp      = 12'h0;
  logic [7:0]  imm       = 8'h0;
  logic        valid;
  logic [31:0] ea;
  logic [31:0] operand;
  logic        mem_acc;
  logic        branch;
  logic        wb_valid;
  logic [31:0] wb_value;
  logic        addr_err;
  int          n_errors  = 0;
  int          n_tests   = 0;
  int          cycles    = 0;

`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

  effective_address_generator u_effective_address_generator (
    .ref_clk_in              (ref_clk),
    .arst_n_in               (arst_n),
    .req_valid_in            (req_valid),
    .mode_in                 (mode),
    .size_in                 (size),
    .imm_kind_in             (kind),
    .selected_general_reg_in (gen_reg),
    .index_reg_zero_in       (idx_reg),
    .global_base_reg_in      (gbase),
    .pc_in                   (pc),
    .disp_in                 (disp),
    .imm_in                  (imm),
    .valid_out               (valid),
    .ea_out                  (ea),
    .operand_out             (operand),
    .mem_access_out          (mem_acc),
    .branch_out              (branch),
    .wb_valid_out            (wb_valid),
    .wb_value_out            (wb_value),
    .addr_error_out          (addr_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic conclude();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One request; keep leaves the strobe up for a back-to-back follower
  task automatic go(ea_mode_e m, op_size_e s, logic [31:0] r = 32'h0, logic [31:0] x = 32'h0,
                    logic [31:0] g = 32'h0, logic [31:0] p = 32'h0, logic [11:0] d = 12'h0,
                    logic [7:0] i = 8'h0, imm_kind_e k = IMM_ZERO_EXT, bit keep = 1'b0);
    if (!req_valid) @(posedge ref_clk);
    req_valid <= 1'b1;
    mode      <= m;
    size      <= s;
    gen_reg   <= r;
    idx_reg   <= x;
    gbase     <= g;
    pc        <= p;
    disp      <= d;
    imm       <= i;
    kind      <= k;
    @(posedge ref_clk);
    if (!keep) req_valid <= 1'b0;
    #1;
  endtask

  // Answer pulse and its qualifiers
  task automatic expect_flags(logic m, logic b, logic w, logic e);
    `CHK(valid, 1'b1)
    `CHK(mem_acc, m)
    `CHK(branch, b)
    `CHK(wb_valid, w)
    `CHK(addr_err, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_direct_indirect();
    go(MODE_REG_DIRECT, SIZE_LONG, 32'h89AB_CDEF);
    expect_flags(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(operand, 32'h89AB_CDEF)
    go(MODE_REG_INDIRECT, SIZE_BYTE, 32'h1234_5673);
    expect_flags(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK(ea, 32'h1234_5673)
  endtask

  task automatic t_steps_and_disp();
    logic [31:0] st;
    for (int j = 0; j < 3; j++) begin
      st = 32'h1 << j;
      go(MODE_POST_INC, op_size_e'(j), 32'hFFFF_FFFC);
      expect_flags(1'b1, 1'b0, 1'b1, 1'b0);
      `CHK(ea, 32'hFFFF_FFFC)
      `CHK(wb_value, 32'hFFFF_FFFC + st)
      go(MODE_PRE_DEC, op_size_e'(j), 32'h0);
      expect_flags(1'b1, 1'b0, 1'b1, 1'b0);
      `CHK(ea, 32'h0 - st)
      `CHK(wb_value, 32'h0 - st)
      go(MODE_REG_DISP4, op_size_e'(j), 32'h0000_1000, 32'h0, 32'h0, 32'h0, 12'hFAF);
      expect_flags(1'b1, 1'b0, 1'b0, 1'b0);
      `CHK(ea, 32'h0000_1000 + 32'hF * st)
      go(MODE_GLOBAL_DISP8, op_size_e'(j), 32'h0, 32'h0, 32'h0000_2000, 32'h0, 12'h0FF);
      `CHK(ea, 32'h0000_2000 + 32'hFF * st)
    end
  endtask

  task automatic t_indexed();
    go(MODE_INDEXED_REG, SIZE_LONG, 32'hFFFF_FFF0, 32'h0000_0014);
    `CHK(ea, 32'h0000_0004)
    go(MODE_INDEXED_GLOBAL, SIZE_WORD, 32'h0, 32'h0000_0100, 32'h0000_3002);
    expect_flags(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK(ea, 32'h0000_3102)
  endtask

  task automatic t_pc_data();
    go(MODE_PC_DISP8, SIZE_WORD, 32'h0, 32'h0, 32'h0, 32'h0000_1002, 12'hAFF);
    `CHK(ea, 32'h0000_1200)
    go(MODE_PC_DISP8, SIZE_LONG, 32'h0, 32'h0, 32'h0, 32'h0000_1003, 12'h0FF);
    expect_flags(1'b1, 1'b0, 1'b0, 1'b0);
    `CHK(ea, 32'h0000_13FC)
  endtask

  task automatic t_branches();
    go(MODE_BRANCH8, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0000_4000, 12'h780);
    expect_flags(1'b0, 1'b1, 1'b0, 1'b0);
    `CHK(ea, 32'h0000_3F00)
    go(MODE_BRANCH8, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0000_4000, 12'h87F);
    `CHK(ea, 32'h0000_40FE)
    go(MODE_BRANCH12, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0000_4000, 12'h800);
    `CHK(ea, 32'h0000_3000)
    go(MODE_BRANCH12, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0000_4000, 12'h7FF);
    `CHK(ea, 32'h0000_4FFE)
    go(MODE_PC_PLUS_REG, SIZE_BYTE, 32'h8000_0000, 32'h0, 32'h0, 32'h8000_0010);
    expect_flags(1'b0, 1'b1, 1'b0, 1'b0);
    `CHK(ea, 32'h0000_0010)
  endtask

  task automatic t_immediates();
    go(MODE_IMMEDIATE, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0, 12'h0, 8'h80, IMM_ZERO_EXT);
    expect_flags(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(operand, 32'h0000_0080)
    go(MODE_IMMEDIATE, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0, 12'h0, 8'h80, IMM_SIGN_EXT);
    `CHK(operand, 32'hFFFF_FF80)
    go(MODE_IMMEDIATE, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0, 12'h0, 8'h7F, IMM_SIGN_EXT);
    `CHK(operand, 32'h0000_007F)
    go(MODE_IMMEDIATE, SIZE_BYTE, 32'h0, 32'h0, 32'h0, 32'h0, 12'h0, 8'hFF, IMM_TRAP);
    `CHK(operand, 32'h0000_03FC)
  endtask

  // Every size against every low address pattern
  task automatic t_alignment();
    logic e;
    for (int j = 0; j < 3; j++) begin
      for (int a = 0; a < 4; a++) begin
        e = (j == 1 && a[0]) || (j == 2 && a[1:0] != 2'b00);
        go(MODE_REG_INDIRECT, op_size_e'(j), 32'h0000_5000 | 32'(a));
        `CHK(addr_err, e)
      end
    end
  endtask

  // Two requests on consecutive edges, then idle holds the values
  task automatic t_back_to_back();
    go(MODE_REG_INDIRECT, SIZE_LONG, 32'h10, 32'h0, 32'h0, 32'h0, 12'h0, 8'h0, IMM_ZERO_EXT, 1'b1);
    `CHK(ea, 32'h0000_0010)
    go(MODE_POST_INC, SIZE_WORD, 32'h20);
    expect_flags(1'b1, 1'b0, 1'b1, 1'b0);
    `CHK(wb_value, 32'h0000_0022)
    @(posedge ref_clk);
    #1;
    `CHK(valid, 1'b0)
    `CHK(wb_valid, 1'b0)
    `CHK(ea, 32'h0000_0020)
    `CHK(wb_value, 32'h0000_0022)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK(valid, 1'b0)
    `CHK(ea, 32'h0)
    `CHK(wb_value, 32'h0)
    repeat (10) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_direct_indirect();
    t_steps_and_disp();
    t_indexed();
    t_pc_data();
    t_branches();
    t_immediates();
    t_alignment();
    t_back_to_back();
    conclude();
  end

endmodule
`default_nettype wire

// File: pkg/ea_gen_pkg.sv
`default_nettype none
package ea_gen_pkg;

  // Datapath width of the core
  localparam int unsigned DATA_W = 32;

  // Addressing modes handled by the generator
  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_REG_DISP4,
    MODE_INDEXED_REG,
    MODE_GLOBAL_DISP8,
    MODE_INDEXED_GLOBAL,
    MODE_PC_DISP8,
    MODE_BRANCH8,
    MODE_BRANCH12,
    MODE_PC_PLUS_REG,
    MODE_IMMEDIATE
  } ea_mode_e;

  // Operand sizes; the fourth code is illegal
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG
  } op_size_e;

  // Immediate extension kinds
  typedef enum logic [1:0] {
    IMM_ZERO_EXT,
    IMM_SIGN_EXT,
    IMM_TRAP
  } imm_kind_e;

  // Step sizes for post-increment and pre-decrement
  localparam logic [DATA_W-1:0] STEP_BYTE    = 32'h0000_0001;
  localparam logic [DATA_W-1:0] STEP_WORD    = 32'h0000_0002;
  localparam logic [DATA_W-1:0] STEP_LONG    = 32'h0000_0004;

  // Program counter mask for longword literal fetch
  localparam logic [DATA_W-1:0] PC_LONG_MASK = 32'hFFFF_FFFC;

  // Field widths of displacements and immediates
  localparam int unsigned DISP4_W  = 4;
  localparam int unsigned DISP8_W  = 8;
  localparam int unsigned DISP12_W = 12;
  localparam int unsigned IMM_W    = 8;

  // Values of the output flops after reset
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;

endpackage
`default_nettype wire
